// ### mpm_pkg.sv
/*
  Shared constants, types and helpers of the power monitor serial port.
  Assumes a single core clock of 125 MHz; no other files are needed.
*/
`default_nettype none

package mpm_pkg;

  // ----------------------------------------------------------------
  // Register pointer values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PTR_CONFIG     = 8'h00;
  localparam logic [7:0]  PTR_SHUNT      = 8'h01;
  localparam logic [7:0]  PTR_BUS        = 8'h02;
  localparam logic [7:0]  PTR_POWER      = 8'h03;
  localparam logic [7:0]  PTR_CURRENT    = 8'h04;
  localparam logic [7:0]  PTR_CAL        = 8'h05;
  localparam logic [15:0] CONFIG_RST_VAL = 16'h4127;
  localparam logic [15:0] RESULT_RST_VAL = 16'h0000;
  localparam int          CONFIG_RST_BIT = 15;

  // ----------------------------------------------------------------
  // Address byte fields
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_PREFIX    = 3'h4;
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
  localparam logic [1:0] STRAP_GND      = 2'h0;
  localparam logic [1:0] STRAP_VS       = 2'h1;
  localparam logic [1:0] STRAP_SDA      = 2'h2;
  localparam logic [1:0] STRAP_SCL      = 2'h3;

  // ----------------------------------------------------------------
  // Arithmetic and timing
  // ----------------------------------------------------------------
  localparam int CURRENT_DIV   = 2048;
  localparam int POWER_DIV     = 20000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TIMEOUT_MS    = 28;
  localparam int TIMEOUT_CYC   =
    int'((longint'(TIMEOUT_MS) * 64'd1000000) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        shunt_vld;
    logic [15:0] shunt;
    logic        bus_vld;
    logic [15:0] bus;
  } mpm_meas_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RECV = 6'h02,
    ST_SACK = 6'h04,
    ST_SEND = 6'h08,
    ST_MACK = 6'h10,
    ST_SKIP = 6'h20
  } mpm_state_e;

  // Clamp a wide signed quotient into the 16-bit result range
  function automatic logic [15:0] mpm_sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) begin
      return 16'h7FFF;
    end else if (v < -48'sh8000) begin
      return 16'h8000;
    end else begin
      return v[15:0];
    end
  endfunction : mpm_sat16

endpackage : mpm_pkg

`default_nettype wire

// ### mpm_strap_decode.sv
/*
  Decodes the two four-state address straps into the seven-bit address.
  Assumes strap, SDA and SCL levels all pass through identical synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none

module mpm_strap_decode (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] strap_in,
  input  wire logic       start_in,
  input  wire logic       first_fall_in,
  output logic      [6:0] addr_out
);

  logic [1:0] prev_r;
  logic [1:0] idle_r;
  logic [1:0] at_start_r;

  // Low with SDA low but high when idle: tied to SDA; high at start
  // but low with SCL low: tied to SCL
  function automatic logic [1:0] code(input logic a, input logic b,
                                      input logic c);
    if (a) begin
      return c ? mpm_pkg::STRAP_VS : mpm_pkg::STRAP_SCL;
    end else begin
      return b ? mpm_pkg::STRAP_SDA : mpm_pkg::STRAP_GND;
    end
  endfunction : code

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_r     <= 2'h0;
      idle_r     <= 2'h0;
      at_start_r <= 2'h0;
    end else begin
      prev_r <= strap_in;
      if (start_in) begin
        at_start_r <= strap_in;
        idle_r     <= prev_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_out <= {mpm_pkg::ADDR_PREFIX, 4'h0};
    end else if (first_fall_in) begin
      addr_out <= {mpm_pkg::ADDR_PREFIX,
                   code(at_start_r[1], idle_r[1], strap_in[1]),
                   code(at_start_r[0], idle_r[0], strap_in[0])};
    end
  end

endmodule : mpm_strap_decode

`default_nettype wire

// ### mpm_power_math.sv
/*
  Current and power result arithmetic.
  Assumes sample strobes are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module mpm_power_math (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cal_set_in,
  input  wire logic [15:0] cal_in,
  input  wire logic        shunt_vld_in,
  input  wire logic [15:0] shunt_in,
  input  wire logic        bus_vld_in,
  input  wire logic [15:0] bus_in,
  output logic      [15:0] current_out,
  output logic      [15:0] power_out
);

  logic signed [32:0] cur_prod;
  logic signed [32:0] pow_prod;
  logic signed [47:0] cur_quo;
  logic signed [47:0] pow_quo;

  // Signed division truncates toward zero
  assign cur_prod = $signed(shunt_in) * $signed({1'b0, cal_in});
  assign cur_quo  = 48'(cur_prod / mpm_pkg::CURRENT_DIV);
  assign pow_prod = $signed(current_out) * $signed({1'b0, bus_in});
  assign pow_quo  = 48'(pow_prod / mpm_pkg::POWER_DIV);

  always_ff @(posedge clk) begin
    if (!rst_n || !cal_set_in) begin
      current_out <= mpm_pkg::RESULT_RST_VAL;
      power_out   <= mpm_pkg::RESULT_RST_VAL;
    end else begin
      if (shunt_vld_in) begin
        current_out <= mpm_pkg::mpm_sat16(cur_quo);
      end
      // Power uses the current from the previous shunt sample
      if (bus_vld_in) begin
        power_out <= mpm_pkg::mpm_sat16(pow_quo);
      end
    end
  end

endmodule : mpm_power_math

`default_nettype wire

// ### mpm_monitor_top.sv
/*
  Serial register port of the current, bus voltage and power monitor,
  with its result registers and arithmetic.
  Assumes an external converter delivers shunt and bus samples on the
  core clock, and that the master alone clocks the serial bus.
*/
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - Current is shunt times calibration over 2048
// - Power is current times bus over 20000
// - Unprogrammed calibration holds current, power zero
// - Programmed calibration updates results per sample
// - Shunt result weighs 2.5uV per bit
// - Bus result weighs 1.25mV per bit
// - Bus result top bit reads zero
// - Power step is 25 current steps
// - Unprogrammed device converts continuously by default
// - Address shifts in on rising clock
// - Matching address and bytes get acknowledged
// - Words move high byte first
// - Data change with clock high frames
// - Stalled transfer released after 28 ms
// - Clock rates 1kHz up to 3.4MHz
// - Address byte is address plus direction
// - Address is 100 plus two strap codes
// - Straps resampled on every transfer
// - First written byte loads register pointer
// - Next two bytes write selected register
// - Read returns high then low byte
// - High-speed code unacknowledged, mode until stop
module mpm_monitor_top #(
  parameter int TIMEOUT_CYC = mpm_pkg::TIMEOUT_CYC
) (
  input  wire logic              REF_CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic              SCL_IN,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE_OUT,
  input  wire logic              ADDR_STRAP_HIGH_IN,
  input  wire logic              ADDR_STRAP_LOW_IN,
  input  wire mpm_pkg::mpm_meas_s MEAS_IN,
  output logic            [15:0] CONFIG_OUT,
  output logic                   HS_MODE_OUT,
  output logic                   BUSY_OUT
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                link_bit_r;
  logic [3:0]          pin_meta_r;
  logic [3:0]          pin_sync_r;
  logic [3:0]          pin_prev_r;
  logic                scl_s;
  logic                sda_s;
  logic                scl_q;
  logic                sda_q;
  logic                start_det;
  logic                stop_det;
  logic                scl_rise;
  logic                scl_fall;
  logic                byte_end;
  logic                first_fall;
  logic                timeout;
  logic [6:0]          own_addr;
  logic                addr_hit;
  logic                hs_code;
  logic                commit;
  logic [15:0]         wr_word;
  logic                soft_rst;
  logic                math_rst_n;
  logic [15:0]         rd_word;
  logic [15:0]         current_w;
  logic [15:0]         power_w;

  mpm_pkg::mpm_state_e state_r;
  logic [3:0]          bit_cnt_r;
  logic [1:0]          byte_idx_r;
  logic [7:0]          shift_r;
  logic                rd_dir_r;
  logic                hs_mode_r;
  logic                sda_oe_r;
  logic [15:0]         tx_r;
  logic [7:0]          wr_hi_r;
  logic [7:0]          ptr_r;
  logic [TW-1:0]       tmo_r;
  logic [15:0]         config_r;
  logic [15:0]         cal_r;
  logic                cal_set_r;
  logic [15:0]         shunt_r;
  logic [15:0]         bus_r;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // Only the data bit is held here. The core reads it after it has
  // seen the synchronised rising edge, when it has long been stable,
  // so no control state needs a reset on a clock that may stand still.
  always_ff @(posedge SCL_IN) begin
    link_bit_r <= SDA_IN;
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Straps share the pipeline with SDA and SCL so that a strap tied
  // to either line shows the same timing as the line itself
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      pin_meta_r <= 4'hF;
      pin_sync_r <= 4'hF;
      pin_prev_r <= 4'hF;
    end else begin
      pin_meta_r <= {SCL_IN, SDA_IN, ADDR_STRAP_HIGH_IN, ADDR_STRAP_LOW_IN};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  assign scl_s = pin_sync_r[3];
  assign sda_s = pin_sync_r[2];
  assign scl_q = pin_prev_r[3];
  assign sda_q = pin_prev_r[2];

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign byte_end  = scl_fall && (bit_cnt_r == 4'h8);
  assign first_fall = scl_fall && (state_r == mpm_pkg::ST_RECV) &&
                      (byte_idx_r == 2'h0) && (bit_cnt_r == 4'h0);
  assign timeout   = (tmo_r == TW'(TIMEOUT_CYC - 1));

  mpm_strap_decode u_strap (
    .clk           (REF_CLK_IN),
    .rst_n         (RST_N_IN),
    .strap_in      (pin_sync_r[1:0]),
    .start_in      (start_det),
    .first_fall_in (first_fall),
    .addr_out      (own_addr)
  );

  assign addr_hit = (shift_r[7:1] == own_addr);
  assign hs_code  = (shift_r[7:3] == mpm_pkg::HS_CODE_PREFIX);

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  assign commit   = byte_end && (state_r == mpm_pkg::ST_RECV) &&
                    (byte_idx_r == 2'h3);
  assign wr_word  = {wr_hi_r, shift_r};
  assign soft_rst = commit && (ptr_r == mpm_pkg::PTR_CONFIG) &&
                    wr_word[mpm_pkg::CONFIG_RST_BIT];

  // ----------------------------------------------------------------
  // Read word select
  // ----------------------------------------------------------------
  always_comb begin
    case (ptr_r)
      mpm_pkg::PTR_CONFIG:  rd_word = config_r;
      mpm_pkg::PTR_SHUNT:   rd_word = shunt_r;
      mpm_pkg::PTR_BUS:     rd_word = bus_r;
      mpm_pkg::PTR_POWER:   rd_word = power_w;
      mpm_pkg::PTR_CURRENT: rd_word = current_w;
      mpm_pkg::PTR_CAL:     rd_word = cal_r;
      default:              rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Protocol state machine
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      state_r    <= mpm_pkg::ST_IDLE;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 2'h0;
      shift_r    <= 8'h00;
      rd_dir_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      tx_r       <= 16'h0000;
    end else if (stop_det || timeout) begin
      state_r  <= mpm_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      // Repeated start keeps the pointer for a following read
      state_r    <= mpm_pkg::ST_RECV;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 2'h0;
      sda_oe_r   <= 1'b0;
    end else begin
      case (state_r)
        mpm_pkg::ST_RECV: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], link_bit_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_end) begin
            bit_cnt_r <= 4'h0;
            if (byte_idx_r != 2'h0) begin
              sda_oe_r   <= 1'b1;
              state_r    <= mpm_pkg::ST_SACK;
              // Extra bytes in one write rewrite the same register
              byte_idx_r <= (byte_idx_r == 2'h3) ? 2'h2 : byte_idx_r + 2'h1;
            end else if (addr_hit) begin
              sda_oe_r   <= 1'b1;
              state_r    <= mpm_pkg::ST_SACK;
              rd_dir_r   <= shift_r[0];
              tx_r       <= rd_word;
              byte_idx_r <= 2'h1;
            end else begin
              state_r <= mpm_pkg::ST_SKIP;
            end
          end
        end
        mpm_pkg::ST_SACK: begin
          if (scl_fall) begin
            if (rd_dir_r) begin
              state_r  <= mpm_pkg::ST_SEND;
              sda_oe_r <= ~tx_r[15];
            end else begin
              state_r  <= mpm_pkg::ST_RECV;
              sda_oe_r <= 1'b0;
            end
          end
        end
        mpm_pkg::ST_SEND: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            // Rotate so a read past the low byte repeats the word
            tx_r <= {tx_r[14:0], tx_r[15]};
            if (bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              sda_oe_r  <= 1'b0;
              state_r   <= mpm_pkg::ST_MACK;
            end else begin
              sda_oe_r <= ~tx_r[14];
            end
          end
        end
        mpm_pkg::ST_MACK: begin
          if (scl_rise) begin
            if (link_bit_r) begin
              state_r <= mpm_pkg::ST_SKIP;
            end else begin
              bit_cnt_r <= 4'h1;
            end
          end else if (scl_fall && bit_cnt_r == 4'h1) begin
            bit_cnt_r <= 4'h0;
            state_r   <= mpm_pkg::ST_SEND;
            sda_oe_r  <= ~tx_r[15];
          end
        end
        mpm_pkg::ST_SKIP: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          state_r  <= mpm_pkg::ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Received byte roles
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      ptr_r   <= mpm_pkg::PTR_CONFIG;
      wr_hi_r <= 8'h00;
    end else if (byte_end && state_r == mpm_pkg::ST_RECV) begin
      if (byte_idx_r == 2'h1) begin
        ptr_r <= shift_r;
      end
      if (byte_idx_r == 2'h2) begin
        wr_hi_r <= shift_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // High-speed mode flag
  // ----------------------------------------------------------------
  // Only the input filters would change; the flag is exported for them
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      hs_mode_r <= 1'b0;
    end else if (stop_det) begin
      hs_mode_r <= 1'b0;
    end else if (byte_end && state_r == mpm_pkg::ST_RECV &&
                 byte_idx_r == 2'h0 && !addr_hit && hs_code) begin
      hs_mode_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus watchdog
  // ----------------------------------------------------------------
  // Any clock edge is progress; a master stalled mid-transfer lets
  // the count run out and the slave lets go of SDA
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      tmo_r <= '0;
    end else if (state_r == mpm_pkg::ST_IDLE || scl_rise || scl_fall ||
                 start_det || timeout) begin
      tmo_r <= '0;
    end else begin
      tmo_r <= tmo_r + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Configuration and calibration registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN || soft_rst) begin
      config_r  <= mpm_pkg::CONFIG_RST_VAL;
      cal_r     <= mpm_pkg::RESULT_RST_VAL;
      cal_set_r <= 1'b0;
    end else if (commit) begin
      if (ptr_r == mpm_pkg::PTR_CONFIG) begin
        config_r <= wr_word;
      end
      if (ptr_r == mpm_pkg::PTR_CAL) begin
        cal_r     <= wr_word;
        cal_set_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Measurement results
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN || soft_rst) begin
      shunt_r <= mpm_pkg::RESULT_RST_VAL;
      bus_r   <= mpm_pkg::RESULT_RST_VAL;
    end else begin
      if (MEAS_IN.shunt_vld) begin
        shunt_r <= MEAS_IN.shunt;
      end
      if (MEAS_IN.bus_vld) begin
        bus_r <= {1'b0, MEAS_IN.bus[14:0]};
      end
    end
  end

  assign math_rst_n = RST_N_IN & ~soft_rst;

  mpm_power_math u_math (
    .clk          (REF_CLK_IN),
    .rst_n        (math_rst_n),
    .cal_set_in   (cal_set_r),
    .cal_in       (cal_r),
    .shunt_vld_in (MEAS_IN.shunt_vld),
    .shunt_in     (MEAS_IN.shunt),
    .bus_vld_in   (MEAS_IN.bus_vld),
    .bus_in       ({1'b0, MEAS_IN.bus[14:0]}),
    .current_out  (current_w),
    .power_out    (power_w)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: the pin is only ever pulled low
  assign SDA_OUT     = 1'b0;
  assign SDA_OE_OUT  = sda_oe_r;
  assign CONFIG_OUT  = config_r;
  assign HS_MODE_OUT = hs_mode_r;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      BUSY_OUT <= 1'b0;
    end else begin
      BUSY_OUT <= (state_r != mpm_pkg::ST_IDLE);
    end
  end

endmodule : mpm_monitor_top

`default_nettype wire

// ### mpm_chk.sv
/* Port checker of mpm_monitor_top, bound at the foot of this file.
   Assumes one core clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module mpm_chk #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic        REF_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        SCL_IN,
  input wire logic        SDA_IN,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_OUT,
  input wire logic [15:0] CONFIG_OUT,
  input wire logic        HS_MODE_OUT,
  input wire logic        BUSY_OUT
);
  // --------------------------------
  // Stall counter
  // --------------------------------
  logic [31:0] idle_r;
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN || !BUSY_OUT || $changed(SCL_IN)) begin
      idle_r <= 32'h0;
    end else begin
      idle_r <= idle_r + 32'h1;
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_sda_value_low: assert property (SDA_OUT == 1'b0)
    else $error("SDA data value not low");
  a_reset_idle: assert property ($rose(RST_N_IN) |->
    !BUSY_OUT && !SDA_OE_OUT && CONFIG_OUT == 16'h4127)
    else $error("outputs not at reset values");
  a_ack_after_fall: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN && !$past(SCL_IN))
    else $error("SDA driven outside SCL low");
  a_data_stable: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_OUT))
    else $error("SDA changed while SCL high");
  a_start_busy: assert property (SCL_IN && $fell(SDA_IN) && !BUSY_OUT
    |-> ##[1:6] BUSY_OUT)
    else $error("start not taken");
  a_hs_stop: assert property (HS_MODE_OUT && SCL_IN && $rose(SDA_IN)
    |-> ##[1:6] !HS_MODE_OUT)
    else $error("high speed flag kept past stop");
  a_hs_no_ack: assert property ($rose(HS_MODE_OUT)
    |-> !SDA_OE_OUT [*8] ##1 !SDA_OE_OUT [*8])
    else $error("high speed code acknowledged");
  a_cfg_in_xfer: assert property ($changed(CONFIG_OUT) |-> BUSY_OUT)
    else $error("config changed outside a transfer");
  // Margin of 8 covers the synchroniser lag and the busy register
  a_stall_release: assert property (idle_r <= 32'(TIMEOUT_CYC + 8))
    else $error("stalled transfer not released");
  c_hs: cover property ($rose(HS_MODE_OUT));
  c_ack: cover property ($rose(SDA_OE_OUT));
  c_stall: cover property (idle_r == 32'(TIMEOUT_CYC));
endmodule : mpm_chk
bind mpm_monitor_top mpm_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_mpm_chk (
  .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .CONFIG_OUT(CONFIG_OUT),
  .HS_MODE_OUT(HS_MODE_OUT), .BUSY_OUT(BUSY_OUT));
`default_nettype wire

// ### mpm_i2c_mst.sv
/* I2C master model, 64 ns bit period; SCL stands high between frames.
   Assumes the bench resolves the open-drain SDA wire into sda_in. */
`timescale 1ns/1ps
`default_nettype none
module mpm_i2c_mst (
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_lo_out
);
  initial begin
    scl_out = 1'b1;
    sda_lo_out = 1'b0;
  end
  task automatic bit_tx(input logic b);
    sda_lo_out = !b;
    #16 scl_out = 1'b1;
    #32 scl_out = 1'b0;
    #16;
  endtask : bit_tx
  task automatic bit_rx(output logic b);
    sda_lo_out = 1'b0;
    #16 scl_out = 1'b1;
    #16 b = sda_in;
    #16 scl_out = 1'b0;
    #16;
  endtask : bit_rx
  // Odd lead-in keeps SCL edges off the core clock edges when st is called on a clock edge
  task automatic st();
    #5 sda_lo_out = 1'b0;
    #16 scl_out = 1'b1;
    #16 sda_lo_out = 1'b1;
    #16 scl_out = 1'b0;
    #16;
  endtask : st
  task automatic sp();
    sda_lo_out = 1'b1;
    #16 scl_out = 1'b1;
    #16 sda_lo_out = 1'b0;
    #16;
  endtask : sp
  task automatic tx(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_tx(d[i]);
    bit_rx(a);
    ack = !a;
  endtask : tx
  task automatic rx(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) bit_rx(d[i]);
    bit_tx(nack);
  endtask : rx
endmodule : mpm_i2c_mst
`default_nettype wire

// ### testbench.sv
/* Self-checking bench of mpm_monitor_top driven by an I2C master model.
   Assumes mpm_pkg, mpm_i2c_mst and mpm_chk are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  localparam int TO = 200;
  logic clk, rst_n, scl, sda_lo, sdo, oe, hs, busy, ack;
  logic [15:0] cfg, s, b, c, cu;
  logic [1:0] sh, sl;
  int seed, n_mismatch, checks, cyc;
  mpm_pkg::mpm_meas_s meas;
  // Open-drain wire with pull-up; straps may follow either bus wire
  wire logic sda = !(sda_lo || (oe && !sdo));
  wire logic [3:0] lv = {scl, sda, 1'b1, 1'b0};
  mpm_monitor_top #(.TIMEOUT_CYC(TO)) i_mpm_monitor_top (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo),
    .SDA_OE_OUT(oe), .ADDR_STRAP_HIGH_IN(lv[sh]), .ADDR_STRAP_LOW_IN(lv[sl]),
    .MEAS_IN(meas), .CONFIG_OUT(cfg), .HS_MODE_OUT(hs), .BUSY_OUT(busy));
  mpm_i2c_mst i_mpm_i2c_mst (.sda_in(sda), .scl_out(scl), .sda_lo_out(sda_lo));
  function automatic logic [15:0] sat(input longint v);
    if (v > 64'sh7FFF) return 16'h7FFF;
    if (v < -64'sh8000) return 16'h8000;
    return v[15:0];
  endfunction : sat
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic smp(input logic [15:0] sv, input logic [15:0] bv);
    @(posedge clk) #1 meas = '{1'b1, sv, 1'b0, bv};
    @(posedge clk) #1 meas = '{1'b0, sv, 1'b1, bv};
    @(posedge clk) #1 meas.bus_vld = 1'b0;
  endtask : smp
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    i_mpm_i2c_mst.st();
    i_mpm_i2c_mst.tx(8'h80, ack);
    `CK(ack, 1'b1)
    i_mpm_i2c_mst.tx(p, ack);
    i_mpm_i2c_mst.tx(v[15:8], ack);
    i_mpm_i2c_mst.tx(v[7:0], ack);
    `CK(ack, 1'b1)
    i_mpm_i2c_mst.sp();
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] v;
    i_mpm_i2c_mst.st();
    i_mpm_i2c_mst.tx(8'h80, ack);
    i_mpm_i2c_mst.tx(p, ack);
    i_mpm_i2c_mst.st();
    i_mpm_i2c_mst.tx(8'h81, ack);
    i_mpm_i2c_mst.rx(v[15:8], 1'b0);
    i_mpm_i2c_mst.rx(v[7:0], 1'b1);
    i_mpm_i2c_mst.sp();
    `CK(v, e)
  endtask : rd
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    seed = 99839;
    meas = '0;
    {sh, sl} = 4'h0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    `CK(cfg, mpm_pkg::CONFIG_RST_VAL)
    smp(16'h1F40, 16'h2570);
    rd(mpm_pkg::PTR_SHUNT, 16'h1F40);
    rd(mpm_pkg::PTR_CURRENT, 16'h0000);
    rd(mpm_pkg::PTR_POWER, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 16'h1F40 : (i == 1) ? 16'h8000 : 16'($random(seed));
      b = (i == 0) ? 16'h2570 : 16'($random(seed));
      c = (i == 0) ? 16'h0A00 : (i == 1) ? 16'hFFFF : 16'($random(seed));
      wr(mpm_pkg::PTR_CAL, c);
      smp(s, b);
      wr(mpm_pkg::PTR_SHUNT, ~s);
      cu = sat(longint'($signed(s)) * longint'(c) / mpm_pkg::CURRENT_DIV);
      rd(mpm_pkg::PTR_SHUNT, s);
      rd(mpm_pkg::PTR_BUS, b & 16'h7FFF);
      rd(mpm_pkg::PTR_CURRENT, cu);
      rd(mpm_pkg::PTR_POWER, sat(longint'($signed(cu)) * longint'(b & 16'h7FFF)
        / mpm_pkg::POWER_DIV));
    end
    for (int k = 0; k < 32; k++) begin
      {sh, sl} = 4'(k / 2);
      repeat (8) @(posedge clk);
      i_mpm_i2c_mst.st();
      i_mpm_i2c_mst.tx({3'h4, 4'(k / 2) ^ 4'(k % 2), 1'b0}, ack);
      `CK(ack, 1'(k % 2 == 0))
      i_mpm_i2c_mst.sp();
    end
    {sh, sl} = 4'h0;
    repeat (8) @(posedge clk);
    i_mpm_i2c_mst.st();
    i_mpm_i2c_mst.tx(8'h0B, ack);
    `CK({ack, hs}, 2'b01)
    rd(mpm_pkg::PTR_BUS, b & 16'h7FFF);
    repeat (8) @(posedge clk);
    `CK(hs, 1'b0)
    i_mpm_i2c_mst.st();
    for (int i = 0; i < 8; i++) i_mpm_i2c_mst.bit_tx(i == 0);
    repeat (4) @(posedge clk);
    `CK(oe, 1'b1)
    repeat (TO + 40) @(posedge clk);
    `CK({busy, oe}, 2'b00)
    i_mpm_i2c_mst.sp();
    wr(mpm_pkg::PTR_CONFIG, 16'h4527);
    rd(mpm_pkg::PTR_CONFIG, 16'h4527);
    wr(mpm_pkg::PTR_CONFIG, 16'hC527);
    rd(mpm_pkg::PTR_CONFIG, mpm_pkg::CONFIG_RST_VAL);
    rd(mpm_pkg::PTR_CURRENT, 16'h0000);
    rd(8'h1C, 16'h0000);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
